/* File: pvs_pkg.sv */
// Shared constants and carrier types for the panel power and video sequencer
package pvs_pkg;

  // Timebase: millisecond tick from the 250 MHz system clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_IN_PS      = 1_000_000_000;
  localparam int CYCLES_PER_MS = MS_IN_PS / CLK_PERIOD_PS;

  // Sequencing limits in milliseconds
  localparam int BLACK_MAX_MS  = 200;
  localparam int HPD_MAX_MS    = 200;
  localparam int SHOW_MAX_MS   = 50;

  // Chosen delays, kept inside the limits above
  localparam int HPD_DELAY_MS  = 20;
  localparam int VALIDATE_MS   = 16;
  localparam int MS_CNT_W      = 8;

  // Sideband register map
  localparam int         AUX_ADDR_W               = 20;
  localparam logic [19:0] VIDEO_DETECT_STATUS_ADDR = 20'h0_0205;
  localparam int         VIDEO_DETECT_BIT         = 0;
  localparam logic [7:0] VIDEO_DETECT_RESET       = 8'h00;

  typedef struct packed {
    logic                  req;
    logic                  wr;
    logic [AUX_ADDR_W-1:0] addr;
  } pvs_aux_req_t;

  typedef struct packed {
    logic       ack;
    logic       nak;
    logic [7:0] rdata;
  } pvs_aux_rsp_t;

endpackage

/* File: pvs_ms_tick.sv */
// Free-running millisecond tick generator
`timescale 1ns/1ps
module pvs_ms_tick #(
  parameter int CYCLES_PER_MS = pvs_pkg::CYCLES_PER_MS
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  output logic      o_tick
);
  import pvs_pkg::*;

  localparam int CW = $clog2(CYCLES_PER_MS + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire           wrap;

  assign wrap    = (cnt_r == CW'(CYCLES_PER_MS - 1));
  assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      o_tick <= wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_tick_gap;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_tick |=> !o_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Millisecond tick repeated on consecutive cycles");

endmodule // pvs_ms_tick

/* File: pvs_panel_seq.sv */
// Sink-side panel power-up and video sequencer with status byte
`timescale 1ns/1ps
module pvs_panel_seq #(
  parameter int CYCLES_PER_MS = pvs_pkg::CYCLES_PER_MS,
  parameter int HPD_DELAY_MS  = pvs_pkg::HPD_DELAY_MS,
  parameter int VALIDATE_MS   = pvs_pkg::VALIDATE_MS
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_video_valid,
  input  wire logic                   i_no_video_flag,
  input  wire logic                   i_black_disable,
  input  wire pvs_pkg::pvs_aux_req_t  i_aux_req,
  output logic                        o_hpd,
  output logic                        o_black_video,
  output logic                        o_video_shown,
  output pvs_pkg::pvs_aux_rsp_t       o_aux_rsp
);
  import pvs_pkg::*;

  localparam logic [MS_CNT_W-1:0] HPD_LIM = MS_CNT_W'(HPD_DELAY_MS);
  localparam logic [MS_CNT_W-1:0] VAL_LIM = MS_CNT_W'(VALIDATE_MS);

  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_BLACK,
    ST_VALIDATE,
    ST_SHOW
  } pvs_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  logic tick;

  pvs_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_ms_tick (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .o_tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state
  pvs_state_t          state_r;
  pvs_state_t          state_nxt;
  logic [MS_CNT_W-1:0] ms_r;
  logic [MS_CNT_W-1:0] ms_nxt;

  wire vid_ok;
  wire shown_nxt;
  wire black_nxt;
  wire hpd_nxt;

  // Flag wins over a valid stream: no stream means black unless i_black_disable is set
  assign vid_ok    = i_video_valid & ~i_no_video_flag;

  always_comb
  begin
    state_nxt = state_r;
    ms_nxt    = ms_r;
    case (state_r)
      ST_POWERUP:
        if (tick)
        begin
          if (ms_r == HPD_LIM - 1'b1)
          begin
            state_nxt = ST_BLACK;
            ms_nxt    = '0;
          end
          else
          begin
            ms_nxt = ms_r + 1'b1;
          end
        end
      ST_BLACK:
        if (vid_ok)
        begin
          state_nxt = ST_VALIDATE;
          ms_nxt    = '0;
        end
      ST_VALIDATE:
        if (!vid_ok)
        begin
          state_nxt = ST_BLACK;
        end
        else if (tick)
        begin
          if (ms_r == VAL_LIM - 1'b1)
          begin
            state_nxt = ST_SHOW;
          end
          else
          begin
            ms_nxt = ms_r + 1'b1;
          end
        end
      ST_SHOW:
        if (!vid_ok)
        begin
          state_nxt = ST_BLACK;
        end
      default:
        state_nxt = ST_POWERUP;
    endcase
  end

  assign hpd_nxt   = (state_nxt != ST_POWERUP);
  assign shown_nxt = (state_nxt == ST_SHOW);
  // Debug override only; production straps it low
  assign black_nxt = ~shown_nxt & ~i_black_disable;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      state_r       <= ST_POWERUP;
      ms_r          <= '0;
      o_hpd         <= 1'b0;
      o_black_video <= 1'b1;
      o_video_shown <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      ms_r          <= ms_nxt;
      o_hpd         <= hpd_nxt;
      o_black_video <= black_nxt;
      o_video_shown <= shown_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sideband register port
  pvs_aux_rsp_t rsp_nxt;
  wire          status_hit;
  wire [7:0]    status_byte;
  wire          ack_nxt;
  wire          nak_nxt;
  wire [7:0]    rdata_nxt;

  assign status_hit  = ~i_aux_req.wr &
                       (i_aux_req.addr == VIDEO_DETECT_STATUS_ADDR);
  assign status_byte = VIDEO_DETECT_RESET |
                       (8'(o_video_shown) << VIDEO_DETECT_BIT);
  // Polls before hot-plug are refused, never acted on
  assign ack_nxt   = i_aux_req.req & o_hpd;
  assign nak_nxt   = i_aux_req.req & ~o_hpd;
  assign rdata_nxt = (ack_nxt & status_hit) ? status_byte : 8'h00;
  assign rsp_nxt   = '{ack: ack_nxt, nak: nak_nxt, rdata: rdata_nxt};

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      o_aux_rsp <= '0;
    end
    else
    begin
      o_aux_rsp <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  logic [MS_CNT_W-1:0] up_ms_r;
  logic [MS_CNT_W-1:0] valid_ms_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      up_ms_r    <= '0;
      valid_ms_r <= '0;
    end
    else
    begin
      if (tick && up_ms_r != '1)
        up_ms_r <= up_ms_r + 1'b1;
      if (!vid_ok || !o_hpd)
        valid_ms_r <= '0;
      else if (tick && valid_ms_r != '1)
        valid_ms_r <= valid_ms_r + 1'b1;
    end
  end

  sequence s_status_read;
    i_aux_req.req && o_hpd && status_hit;
  endsequence

  sequence s_video_lost;
    o_video_shown && !i_video_valid;
  endsequence

  property p_black_power_up;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !o_hpd |-> o_black_video || $past(i_black_disable);
  endproperty
  a_black_power_up: assert property (p_black_power_up)
    else $error("Black video missing before hot-plug");

  property p_hpd_limit;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (up_ms_r >= MS_CNT_W'(HPD_MAX_MS)) |-> o_hpd;
  endproperty
  a_hpd_limit: assert property (p_hpd_limit)
    else $error("Hot-plug not high within its limit");

  property p_aux_ready;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_aux_req.req && o_hpd) |=> o_aux_rsp.ack && !o_aux_rsp.nak;
  endproperty
  a_aux_ready: assert property (p_aux_ready)
    else $error("Sideband request not answered after hot-plug");

  property p_aux_poll;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_aux_req.req && !o_hpd) |=> o_aux_rsp.nak && !o_aux_rsp.ack;
  endproperty
  a_aux_poll: assert property (p_aux_poll)
    else $error("Early sideband poll not refused");

  property p_show_limit;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (valid_ms_r >= MS_CNT_W'(SHOW_MAX_MS)) |-> o_video_shown;
  endproperty
  a_show_limit: assert property (p_show_limit)
    else $error("Valid video not shown within its limit");

  property p_status_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_status_read |=>
        o_aux_rsp.rdata[VIDEO_DETECT_BIT] == $past(o_video_shown);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status bit does not follow video detection");

  property p_video_drop;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_video_lost |=> !o_video_shown ##1 !o_video_shown;
  endproperty
  a_video_drop: assert property (p_video_drop)
    else $error("Video still shown after loss");

  property p_no_video_flag;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_no_video_flag && !i_black_disable) |=>
        !o_video_shown && o_black_video;
  endproperty
  a_no_video_flag: assert property (p_no_video_flag)
    else $error("No-video flag did not force black video");

  property p_debug_off;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_black_disable |=> !o_black_video;
  endproperty
  a_debug_off: assert property (p_debug_off)
    else $error("Black video not disabled by debug input");

endmodule // pvs_panel_seq

/* File: pvs_source_model.sv */
// Display source model: sideband reads with retry on refusal
`timescale 1ns/1ps
module pvs_source_model
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_start,
  input  wire logic                  i_wr,
  input  wire logic [19:0]           i_addr,
  input  wire pvs_pkg::pvs_aux_rsp_t i_aux_rsp,
  output pvs_pkg::pvs_aux_req_t      o_aux_req,
  output logic                       o_done,
  output logic [7:0]                 o_rdata,
  output logic [7:0]                 o_retries
);
  import pvs_pkg::*;
  // Backlight and supply pins are not at these ports
  logic got;
  logic seen;

  initial
  begin
    o_aux_req = '0;
    o_done    = 1'b0;
    o_rdata   = 8'h00;
    o_retries = 8'h00;
  end

  always
  begin
    @(posedge i_sys_clk iff i_start);
    o_done    = 1'b0;
    o_retries = 8'h00;
    got       = 1'b0;
    while (!got)
    begin
      @(negedge i_sys_clk);
      o_aux_req = '{req: 1'b1, wr: i_wr, addr: i_addr};
      @(negedge i_sys_clk);
      o_aux_req.req  = 1'b0;
      // Released address must not look valid
      o_aux_req.addr = ~i_addr;
      seen = 1'b0;
      repeat (3)
      begin
        @(posedge i_sys_clk);
        if (!seen && i_aux_rsp.ack)
        begin
          got     = 1'b1;
          seen    = 1'b1;
          o_rdata = i_aux_rsp.rdata;
        end
        else if (!seen && i_aux_rsp.nak)
        begin
          seen      = 1'b1;
          o_retries = o_retries + 8'h01;
        end
      end
    end
    o_done = 1'b1;
  end
endmodule // pvs_source_model

/* File: pvs_panel_seq_bench.sv */
// Self-checking bench for the panel power and video sequencer
`timescale 1ns/1ps
module pvs_panel_seq_bench;
  import pvs_pkg::*;
  // Short millisecond keeps the run small
  localparam int CPM = 10;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         video = 1'b0;
  logic         flag = 1'b0;
  logic         dis = 1'b0;
  logic         start = 1'b0;
  logic         wr = 1'b0;
  logic [19:0]  addr = 20'h0_0205;
  pvs_aux_req_t req;
  pvs_aux_rsp_t rsp;
  logic         hpd, black, shown, done;
  logic [7:0]   rdata, retries;
  int           num_errors = 0;
  int           compares = 0;
  int           n;

  always #2 clk = ~clk;

  pvs_panel_seq #(.CYCLES_PER_MS(CPM)) dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_video_valid(video),
    .i_no_video_flag(flag), .i_black_disable(dis), .i_aux_req(req),
    .o_hpd(hpd), .o_black_video(black), .o_video_shown(shown),
    .o_aux_rsp(rsp));

  pvs_source_model src (
    .i_sys_clk(clk), .i_start(start), .i_wr(wr), .i_addr(addr),
    .i_aux_rsp(rsp),
    .o_aux_req(req), .o_done(done), .o_rdata(rdata),
    .o_retries(retries));

  task end_of_test;
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait: 0 hot-plug, 1 video shown, 2 read done
  task wait_until(input int sel, input int limit);
    n = 0;
    while (n < limit && (sel == 0 ? hpd : sel == 1 ? shown : done) !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    if ((sel == 0 ? hpd : sel == 1 ? shown : done) !== 1'b1)
    begin
      check(8'h00, 8'h01);
      end_of_test;
    end
  endtask

  task read_reg(input logic [19:0] a, input logic [7:0] exp);
    addr  = a;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_until(2, 4000);
    check(rdata, exp);
  endtask

  task reset_dut;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({hpd, black, shown}, 8'h02);
  endtask

  task t_power_up;
    reset_dut();
    read_reg(20'h0_0205, 8'h00);
    check(retries != 8'h00, 8'h01);
    check(hpd, 8'h01);
    check(n <= 200 * CPM, 8'h01);
  endtask

  task t_video_on;
    // Status register read done above, link assumed trained
    video = 1'b1;
    wait_until(1, 50 * CPM + 2);
    check(black, 8'h00);
    read_reg(20'h0_0205, 8'h01);
    read_reg(20'h0_0206, 8'h00);
    // Status byte is read-only: a write is acked and leaves it alone
    wr = 1'b1;
    read_reg(20'h0_0205, 8'h00);
    wr = 1'b0;
    read_reg(20'h0_0205, 8'h01);
  endtask

  task t_video_off;
    video = 1'b0;
    @(negedge clk);
    check({shown, black}, 8'h01);
    read_reg(20'h0_0205, 8'h00);
  endtask

  task t_flag;
    video = 1'b1;
    wait_until(1, 50 * CPM + 2);
    flag = 1'b1;
    @(negedge clk);
    check({shown, black}, 8'h01);
    video = 1'b0;
    flag  = 1'b0;
    @(negedge clk);
  endtask

  task t_debug;
    dis = 1'b1;
    @(negedge clk);
    check(black, 8'h00);
    dis = 1'b0;
    @(negedge clk);
    check(black, 8'h01);
  endtask

  task t_mid_reset;
    video = 1'b1;
    wait_until(1, 50 * CPM + 2);
    // Supply goes only after video stops
    video = 1'b0;
    @(negedge clk);
    reset_dut();
    read_reg(20'h0_0205, 8'h00);
    check(retries != 8'h00, 8'h01);
  endtask

  initial
  begin
    t_power_up();
    t_video_on();
    t_video_off();
    t_flag();
    t_debug();
    t_mid_reset();
    end_of_test();
  end
endmodule // pvs_panel_seq_bench
